// >>> core/iph_map.vh
`ifndef IPH_MAP_VH
`define IPH_MAP_VH

// Register byte offsets
`define IPH_DEVICE_STATE_OFS  8'h00
`define IPH_ERROR_REPORT_OFS  8'h04
`define IPH_TIMER_PERIOD_OFS  8'h08
`define IPH_UNIT_SELECT_OFS   8'h0c
`define IPH_COMMAND_CODE_OFS  8'h10
`define IPH_CONTROL_OFS       8'h14
`define IPH_IRQ_STATUS_OFS    8'h18
`define IPH_IRQ_MASK_OFS      8'h1c
`define IPH_POWER_MODE_OFS    8'h20

// device_state fields
`define IPH_ST_BUSY    7
`define IPH_ST_READY   6
`define IPH_ST_FAULT   5
`define IPH_ST_XFER    3
`define IPH_ST_ERROR   0
// error_report field
`define IPH_ERR_ABORT  2
// unit_select field
`define IPH_UNIT_BIT   4
// control fields
`define IPH_CTL_PM     0
`define IPH_CTL_UNIT   1
// irq status / mask fields
`define IPH_IRQ_DONE    0
`define IPH_IRQ_STANDBY 1

// Reset values
`define IPH_STATE_RST    8'h40
`define IPH_CONTROL_RST  8'h01
`define IPH_MASK_RST     8'h00

// Command codes
`define IPH_CMD_IDLE      8'he3
`define IPH_CMD_IDLE_NOW  8'he1

// Timer codes
`define IPH_TC_OFF        8'h00
`define IPH_TC_5S_LAST    8'hf0
`define IPH_TC_30M_LAST   8'hfb
`define IPH_TC_21M        8'hfc
`define IPH_TC_LONG       8'hfd
`define IPH_TC_RSVD       8'hfe
`define IPH_TC_21M15      8'hff
`define IPH_TC_30M_BASE   13'd240

// Periods in units of the 5 s base tick, 13 bits to hold the long period
`define IPH_UNITS_30M     13'd360
`define IPH_UNITS_21M     13'd252
`define IPH_UNITS_LONG    13'd7200
`define IPH_UNITS_21M15   13'd255

// Timing
`define IPH_TICK_S        5
`define IPH_CLK_HZ        250000000

// AXI responses
`define IPH_RESP_OKAY     2'b00
`define IPH_RESP_SLVERR   2'b10

`endif

// >>> core/iph_idle_power_handler.v
// The register offsets and the AXI4-Lite register port were left to the implementer.
`include "iph_map.vh"

module iph_idle_power_handler #(
  parameter [30:0] TICK_CYCLES = `IPH_TICK_S * `IPH_CLK_HZ
) (
  input  wire        clock,
  input  wire        rst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        deviceFault,
  output reg         interruptRequest,
  output wire        irq,
  output reg         idleMode,
  output reg         standbyMode
);

  localparam [2:0] S_READY = 3'b001;
  localparam [2:0] S_EXEC  = 3'b010;
  localparam [2:0] S_DONE  = 3'b100;

  // Period code to count of 5 s ticks; zero for off or reserved
  function [12:0] periodUnits;
    input [7:0] code;
    begin
      if (code == `IPH_TC_OFF || code == `IPH_TC_RSVD)
        periodUnits = 13'd0;
      else if (code <= `IPH_TC_5S_LAST)
        periodUnits = {5'h00, code};
      else if (code <= `IPH_TC_30M_LAST)
        periodUnits = ({5'h00, code} - `IPH_TC_30M_BASE)
                      * `IPH_UNITS_30M;
      else if (code == `IPH_TC_21M)
        periodUnits = `IPH_UNITS_21M;
      else if (code == `IPH_TC_LONG)
        periodUnits = `IPH_UNITS_LONG;
      else
        periodUnits = `IPH_UNITS_21M15;
    end
  endfunction

  reg [2:0]  fsm_reg;
  reg [7:0]  state_reg;
  reg [7:0]  error_reg;
  reg [7:0]  period_reg;
  reg [7:0]  unit_reg;
  reg [7:0]  cmd_reg;
  reg [7:0]  control_reg;
  reg [1:0]  irqStatus_reg;
  reg [1:0]  irqMask_reg;
  reg        timerOn_reg;
  reg [12:0] timerLoad_reg;
  reg [12:0] units_reg;
  reg [30:0] tick_reg;

  reg        awHeld_reg;
  reg [7:0]  awAddr_reg;
  reg        wHeld_reg;
  reg [31:0] wData_reg;
  reg [3:0]  wStrb_reg;

  wire        pmSupported = control_reg[`IPH_CTL_PM];
  wire        thisUnit    = control_reg[`IPH_CTL_UNIT];

  // Write channel: address and data taken in either order
  assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire        awTake  = s_axi_awvalid && s_axi_awready;
  wire        wTake   = s_axi_wvalid && s_axi_wready;
  wire        awHave  = awHeld_reg || awTake;
  wire        wHave   = wHeld_reg || wTake;
  wire        doWrite = awHave && wHave;
  wire [7:0]  wrAddr  = awHeld_reg ? awAddr_reg : s_axi_awaddr;
  wire [31:0] wrData  = wHeld_reg ? wData_reg : s_axi_wdata;
  wire [3:0]  wrStrb  = wHeld_reg ? wStrb_reg : s_axi_wstrb;
  wire        wrLow   = doWrite && wrStrb[0];
  wire        arTake  = s_axi_arvalid && s_axi_arready;

  wire wrMapped = (wrAddr == `IPH_DEVICE_STATE_OFS) ||
                  (wrAddr == `IPH_ERROR_REPORT_OFS) ||
                  (wrAddr == `IPH_TIMER_PERIOD_OFS) ||
                  (wrAddr == `IPH_UNIT_SELECT_OFS) ||
                  (wrAddr == `IPH_COMMAND_CODE_OFS) ||
                  (wrAddr == `IPH_CONTROL_OFS) ||
                  (wrAddr == `IPH_IRQ_STATUS_OFS) ||
                  (wrAddr == `IPH_IRQ_MASK_OFS) ||
                  (wrAddr == `IPH_POWER_MODE_OFS);

  // Command accepted only when ready and addressed to this unit
  wire cmdWrite  = wrLow && (wrAddr == `IPH_COMMAND_CODE_OFS);
  wire cmdStart  = cmdWrite && (fsm_reg == S_READY) &&
                   state_reg[`IPH_ST_READY] &&
                   (unit_reg[`IPH_UNIT_BIT] == thisUnit);
  wire isIdle    = cmd_reg == `IPH_CMD_IDLE;
  wire isIdleNow = cmd_reg == `IPH_CMD_IDLE_NOW;
  wire badCode   = isIdle && (period_reg == `IPH_TC_RSVD);
  wire abortCmd  = !pmSupported || badCode ||
                   !(isIdle || isIdleNow);
  wire finish    = fsm_reg == S_EXEC;

  wire readState = arTake && (s_axi_araddr == `IPH_DEVICE_STATE_OFS);
  wire readIrq   = arTake && (s_axi_araddr == `IPH_IRQ_STATUS_OFS);
  wire tickDone  = tick_reg == TICK_CYCLES - 31'd1;
  wire expire    = timerOn_reg && idleMode && tickDone &&
                   (units_reg == 13'd1) && !cmdWrite;

  // Channel holding registers
  always @(posedge clock) begin
    if (rst) begin
      awHeld_reg   <= 1'b0;
      awAddr_reg   <= 8'h00;
      wHeld_reg    <= 1'b0;
      wData_reg    <= 32'h00000000;
      wStrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `IPH_RESP_OKAY;
    end else begin
      if (doWrite) begin
        awHeld_reg   <= 1'b0;
        wHeld_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMapped ? `IPH_RESP_OKAY : `IPH_RESP_SLVERR;
      end else begin
        if (awTake) begin
          awHeld_reg <= 1'b1;
          awAddr_reg <= s_axi_awaddr;
        end
        if (wTake) begin
          wHeld_reg <= 1'b1;
          wData_reg <= s_axi_wdata;
          wStrb_reg <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel
  always @(posedge clock) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `IPH_RESP_OKAY;
    end else if (arTake) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `IPH_RESP_OKAY;
      case (s_axi_araddr)
        `IPH_DEVICE_STATE_OFS: s_axi_rdata <= {24'h000000, state_reg};
        `IPH_ERROR_REPORT_OFS: s_axi_rdata <= {24'h000000, error_reg};
        `IPH_TIMER_PERIOD_OFS: s_axi_rdata <= {24'h000000, period_reg};
        `IPH_UNIT_SELECT_OFS:  s_axi_rdata <= {24'h000000, unit_reg};
        `IPH_COMMAND_CODE_OFS: s_axi_rdata <= 32'h00000000;
        `IPH_CONTROL_OFS:      s_axi_rdata <= {24'h000000, control_reg};
        `IPH_IRQ_STATUS_OFS:   s_axi_rdata <= {30'h00000000, irqStatus_reg};
        `IPH_IRQ_MASK_OFS:     s_axi_rdata <= {30'h00000000, irqMask_reg};
        `IPH_POWER_MODE_OFS:
          s_axi_rdata <= {29'h00000000, timerOn_reg, standbyMode, idleMode};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `IPH_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Software-written registers
  always @(posedge clock) begin
    if (rst) begin
      period_reg  <= 8'h00;
      unit_reg    <= 8'h00;
      control_reg <= `IPH_CONTROL_RST;
      irqMask_reg <= 2'b00;
    end else if (wrLow) begin
      case (wrAddr)
        `IPH_TIMER_PERIOD_OFS: period_reg  <= wrData[7:0];
        `IPH_UNIT_SELECT_OFS:  unit_reg    <= wrData[7:0];
        `IPH_CONTROL_OFS:      control_reg <= {6'h00, wrData[1:0]};
        `IPH_IRQ_MASK_OFS:     irqMask_reg <= wrData[1:0];
        default: ;
      endcase
    end
  end

  // Command sequencer
  always @(posedge clock) begin
    if (rst) begin
      fsm_reg   <= S_READY;
      state_reg <= `IPH_STATE_RST;
      error_reg <= 8'h00;
      cmd_reg   <= 8'h00;
    end else begin
      case (fsm_reg)
        S_READY: begin
          if (cmdStart) begin
            cmd_reg                  <= wrData[7:0];
            state_reg[`IPH_ST_BUSY]  <= 1'b1;
            state_reg[`IPH_ST_READY] <= 1'b0;
            fsm_reg                  <= S_EXEC;
          end
        end
        S_EXEC: begin
          state_reg[`IPH_ST_BUSY]  <= 1'b0;
          state_reg[`IPH_ST_READY] <= 1'b1;
          state_reg[`IPH_ST_XFER]  <= 1'b0;
          if (abortCmd) begin
            error_reg                <= 8'h04;
            state_reg[`IPH_ST_FAULT] <= deviceFault;
            state_reg[`IPH_ST_ERROR] <= 1'b1;
          end else begin
            error_reg                <= 8'h00;
            state_reg[`IPH_ST_FAULT] <= 1'b0;
            state_reg[`IPH_ST_ERROR] <= 1'b0;
          end
          fsm_reg <= S_DONE;
        end
        S_DONE: fsm_reg <= S_READY;
        default: fsm_reg <= S_READY;
      endcase
    end
  end

  // Host interrupt: set on completion, cleared by reading device_state
  always @(posedge clock) begin
    if (rst)
      interruptRequest <= 1'b0;
    else if (finish)
      interruptRequest <= 1'b1;
    else if (readState)
      interruptRequest <= 1'b0;
  end

  // Sticky events, read clears, set wins
  always @(posedge clock) begin
    if (rst)
      irqStatus_reg <= 2'b00;
    else
      irqStatus_reg <= (readIrq ? 2'b00 : irqStatus_reg) |
                       {expire, finish};
  end

  assign irq = |(irqStatus_reg & irqMask_reg);

  // Power mode and standby timer
  always @(posedge clock) begin
    if (rst) begin
      idleMode      <= 1'b1;
      standbyMode   <= 1'b0;
      timerOn_reg   <= 1'b0;
      timerLoad_reg <= 13'd0;
      units_reg     <= 13'd0;
      tick_reg      <= 31'd0;
    end else if (finish && !abortCmd) begin
      idleMode    <= 1'b1;
      standbyMode <= 1'b0;
      tick_reg    <= 31'd0;
      if (isIdle) begin
        timerOn_reg   <= period_reg != `IPH_TC_OFF;
        timerLoad_reg <= periodUnits(period_reg);
        units_reg     <= periodUnits(period_reg);
      end else begin
        units_reg <= timerLoad_reg;
      end
    end else if (cmdWrite) begin
      tick_reg  <= 31'd0;
      units_reg <= timerLoad_reg;
    end else if (expire) begin
      idleMode    <= 1'b0;
      standbyMode <= 1'b1;
    end else if (timerOn_reg && idleMode) begin
      if (tickDone) begin
        tick_reg  <= 31'd0;
        units_reg <= units_reg - 13'd1;
      end else begin
        tick_reg <= tick_reg + 31'd1;
      end
    end
  end

endmodule // iph_idle_power_handler

// >>> dv/iph_sva.sv
module iph_sva (
  input wire logic clock,
  input wire logic rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic interruptRequest,
  input wire logic idleMode,
  input wire logic standbyMode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("bvalid dropped early");
  property p_rdans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rdans: assert property (p_rdans)
    else $error("read answer late");
  property p_awblk; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_awblk: assert property (p_awblk)
    else $error("write taken with response pending");
  property p_modes; !(idleMode && standbyMode); endproperty
  a_modes: assert property (p_modes)
    else $error("idle and standby together");
  property p_sbyent; $rose(standbyMode) |-> $fell(idleMode); endproperty
  a_sbyent: assert property (p_sbyent)
    else $error("standby entered not from idle");
  property p_irqset; $rose(interruptRequest) |-> $past(s_axi_bvalid);
  endproperty
  a_irqset: assert property (p_irqset)
    else $error("interrupt without command write");
  property p_irqclr;
    $fell(interruptRequest) |->
      $past(rst) || $past(s_axi_arvalid && s_axi_arready);
  endproperty
  a_irqclr: assert property (p_irqclr)
    else $error("interrupt cleared without read");
  property p_rstv;
    $fell(rst) |-> !interruptRequest && idleMode && !standbyMode;
  endproperty
  a_rstv: assert property (p_rstv)
    else $error("bad state after reset");
  c_sby: cover property ($rose(standbyMode));
  c_irq: cover property ($rose(interruptRequest));
  c_rd: cover property (s_axi_arvalid && s_axi_arready);
endmodule // iph_sva

bind iph_idle_power_handler iph_sva u_sva (.clock(clock), .rst(rst),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .interruptRequest(interruptRequest), .idleMode(idleMode),
  .standbyMode(standbyMode));

// >>> dv/iph_host.sv
module iph_host (
  input  wire logic   clock,
  output logic [7:0]  s_axi_awaddr,
  output logic        s_axi_awvalid,
  input  wire logic   s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0]  s_axi_wstrb,
  output logic        s_axi_wvalid,
  input  wire logic   s_axi_wready,
  input  wire logic   s_axi_bvalid,
  output logic        s_axi_bready,
  output logic [7:0]  s_axi_araddr,
  output logic        s_axi_arvalid,
  input  wire logic   s_axi_arready,
  input  wire logic   s_axi_rvalid,
  output logic        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output bit ok);
    int n = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
      n++;
    end while (n < 40 && (s_axi_awvalid | s_axi_wvalid | s_axi_bready));
    ok = n < 40;
  endtask
  task automatic rd(input logic [7:0] a, output bit ok);
    int n = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b0;
      n++;
    end while (n < 40 && (s_axi_arvalid | s_axi_rready));
    ok = n < 40;
  endtask
endmodule // iph_host

// >>> dv/tb_iph_idle_power_handler.sv
`include "iph_map.vh"
module tb_iph_idle_power_handler;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 64;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        deviceFault = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, interruptRequest, irq;
  logic idleMode, standbyMode;
  logic [7:0]  codes [8] = '{8'h00, 8'h01, 8'hf0, 8'hf1, 8'hfb, 8'hfc,
                             8'hfd, 8'hff};
  logic [33:0] expR [$];
  logic [1:0]  expB [$];
  int          bad_count = 0;
  int          checks_done = 0;
  int          c;
  int          n;
  always #2 clock = ~clock;
  iph_idle_power_handler #(.TICK_CYCLES(31'd64)) dut (.*);
  iph_host host (.*);
  task automatic check(input string what, input logic [33:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Monitor pairs each bus answer with the oldest note
  always @(posedge clock) begin
    if (s_axi_rvalid && s_axi_rready)
      check("read", {s_axi_rresp, s_axi_rdata}, expR.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      check("bresp", 34'(s_axi_bresp), 34'(expB.pop_front()));
  end
  task automatic bus_ok(input bit ok);
    if (!ok) begin
      bad_count++;
      test_done();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = `IPH_RESP_OKAY);
    bit ok;
    expB.push_back(r);
    host.wr(a, d, ok);
    bus_ok(ok);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = `IPH_RESP_OKAY);
    bit ok;
    expR.push_back({r, d});
    host.rd(a, ok);
    bus_ok(ok);
  endtask
  task automatic cmd(input logic [7:0] code, input logic [7:0] pre);
    rd(`IPH_DEVICE_STATE_OFS, {24'h0, pre});
    wr(`IPH_COMMAND_CODE_OFS, {24'h0, code});
  endtask
  task automatic wait_sby(input int lim);
    for (n = 0; n < lim && standbyMode !== 1'b1; n++) @(posedge clock);
    check("standby", 34'(standbyMode), 34'h1);
    check("idle", 34'(idleMode), 34'h0);
    if (standbyMode !== 1'b1) test_done();
  endtask
  initial begin
    void'($urandom(32'h8d83));
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rd(`IPH_DEVICE_STATE_OFS, 32'h40);
    rd(`IPH_ERROR_REPORT_OFS, 32'h0);
    rd(`IPH_CONTROL_OFS, 32'h1);
    rd(`IPH_POWER_MODE_OFS, 32'h1);
    rd(8'h24, 32'h0, `IPH_RESP_SLVERR);
    wr(8'h24, 32'h0, `IPH_RESP_SLVERR);
    $display("reset test done");
    foreach (codes[i]) begin
      wr(`IPH_TIMER_PERIOD_OFS, {24'h0, codes[i]});
      cmd(`IPH_CMD_IDLE, 8'h40);
      @(posedge clock);
      #1 check("line", 34'(interruptRequest), 34'h1);
      check("masked", 34'(irq), 34'h0);
      rd(`IPH_POWER_MODE_OFS, {29'h0, codes[i] != 8'h0, 2'h1});
      rd(`IPH_DEVICE_STATE_OFS, 32'h40);
    end
    $display("timer code test done");
    wr(`IPH_TIMER_PERIOD_OFS, 32'hfe);
    @(posedge clock) deviceFault <= 1'b1;
    cmd(`IPH_CMD_IDLE, 8'h40);
    rd(`IPH_ERROR_REPORT_OFS, 32'h4);
    rd(`IPH_DEVICE_STATE_OFS, 32'h61);
    rd(`IPH_POWER_MODE_OFS, 32'h5);
    @(posedge clock) deviceFault <= 1'b0;
    cmd(`IPH_CMD_IDLE_NOW, 8'h61);
    rd(`IPH_ERROR_REPORT_OFS, 32'h0);
    wr(`IPH_CONTROL_OFS, 32'h0);
    cmd(`IPH_CMD_IDLE_NOW, 8'h40);
    rd(`IPH_ERROR_REPORT_OFS, 32'h4);
    wr(`IPH_CONTROL_OFS, 32'h1);
    $display("abort test done");
    wr(`IPH_UNIT_SELECT_OFS, 32'h10);
    cmd(`IPH_CMD_IDLE_NOW, 8'h41);
    wr(`IPH_CONTROL_OFS, 32'h3);
    cmd(`IPH_CMD_IDLE_NOW, 8'h41);
    rd(`IPH_DEVICE_STATE_OFS, 32'h40);
    $display("unit select test done");
    rd(`IPH_IRQ_STATUS_OFS, 32'h1);
    wr(`IPH_IRQ_MASK_OFS, 32'h1);
    cmd(`IPH_CMD_IDLE_NOW, 8'h40);
    @(posedge clock);
    #1 check("irq", 34'(irq), 34'h1);
    rd(`IPH_IRQ_STATUS_OFS, 32'h1);
    check("irq", 34'(irq), 34'h0);
    $display("interrupt test done");
    c = $urandom_range(4, 1);
    wr(`IPH_TIMER_PERIOD_OFS, c);
    cmd(`IPH_CMD_IDLE, 8'h40);
    repeat (c * T - 12) @(posedge clock);
    check("early", 34'(standbyMode), 34'h0);
    wait_sby(30);
    rd(`IPH_POWER_MODE_OFS, 32'h6);
    rd(`IPH_IRQ_STATUS_OFS, 32'h3);
    cmd(`IPH_CMD_IDLE_NOW, 8'h40);
    rd(`IPH_POWER_MODE_OFS, 32'h5);
    wait_sby(c * T + 30);
    $display("standby test done");
    test_done();
  end
endmodule // tb_iph_idle_power_handler
